// *** logic/sacq_pkg.sv ***
// Package for the scope acquisition state control block: register map, fields, states and constants
package sacq_pkg;

    localparam int SACQ_DW = 16;

    // Register byte addresses on the Wishbone slave
    localparam logic [7:0] SACQ_A_CTRL = 8'h00;
    localparam logic [7:0] SACQ_A_PRE = 8'h04;
    localparam logic [7:0] SACQ_A_LEN = 8'h08;
    localparam logic [7:0] SACQ_A_HOLD = 8'h0c;
    localparam logic [7:0] SACQ_A_LEVEL = 8'h10;
    localparam logic [7:0] SACQ_A_WIDTH = 8'h14;
    localparam logic [7:0] SACQ_A_STRM = 8'h18;
    localparam logic [7:0] SACQ_A_STAT = 8'h1c;
    localparam logic [7:0] SACQ_A_CMD = 8'h20;

    // Control register fields
    localparam int SACQ_C_TRIG_EN = 0;
    localparam int SACQ_C_GATE_EN = 1;
    localparam int SACQ_C_RUN = 2;
    localparam int SACQ_C_SRC_LO = 4;
    localparam int SACQ_C_SRC_HI = 6;
    localparam int SACQ_C_OSEL_LO = 8;
    localparam int SACQ_C_OSEL_HI = 10;
    // Command register fields (write-only pulses)
    localparam int SACQ_K_START = 0;
    localparam int SACQ_K_STOP = 1;
    localparam int SACQ_K_FORCE = 2;
    // Streaming register fields
    localparam int SACQ_S_EN0 = 0;
    localparam int SACQ_S_EN1 = 1;
    localparam int SACQ_S_DIV_LO = 8;
    localparam int SACQ_S_DIV_HI = 23;

    localparam logic [31:0] SACQ_CTRL_RST = 32'h0000_0001;
    localparam logic [15:0] SACQ_PRE_RST = 16'h0010;
    localparam logic [15:0] SACQ_LEN_RST = 16'h0040;
    localparam logic [15:0] SACQ_HOLD_RST = 16'h0020;
    localparam logic [15:0] SACQ_LEVEL_RST = 16'h0000;
    localparam logic [7:0] SACQ_WIDTH_RST = 8'h00;
    localparam logic [31:0] SACQ_STRM_RST = 32'h0000_0000;
    localparam logic [15:0] SACQ_ONE = 16'h0001;
    localparam logic [15:0] SACQ_ZERO = 16'h0000;
    localparam int SACQ_NSRC = 5;
    localparam int SACQ_NCH = 2;
    localparam logic [31:0] SACQ_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        SACQ_IDLE = 2'b00,
        SACQ_BUFFER = 2'b01,
        SACQ_ARMED = 2'b10,
        SACQ_ACTIVE = 2'b11
    } sacq_state_e;

    // Trigger output select: 0/1 trigger pulse, 2/3 armed state, 4/5 active state; odd codes invert
    typedef enum logic [2:0] {
        SACQ_OUT_TRIG = 3'b000,
        SACQ_OUT_TRIG_N = 3'b001,
        SACQ_OUT_ARMED = 3'b010,
        SACQ_OUT_ARMED_N = 3'b011,
        SACQ_OUT_ACTIVE = 3'b100,
        SACQ_OUT_ACTIVE_N = 3'b101
    } sacq_osel_e;

    typedef struct packed {
        logic valid;
        logic [SACQ_DW-1:0] data;
    } sacq_smp_s;

    typedef struct packed {
        logic [SACQ_NCH-1:0] valid;
        logic [SACQ_NCH-1:0][SACQ_DW-1:0] data;
    } sacq_strm_s;

endpackage : sacq_pkg

// *** logic/sacq_top.sv ***
// Scope acquisition sequencer with trigger logic, streaming path and Wishbone registers
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module sacq_top (
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic [31:0] wb_adr_i, // Wishbone address
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    output logic wb_ack_o, // Wishbone acknowledge
    input wire sacq_pkg::sacq_smp_s smp_i, // Shot sample input
    input wire logic [sacq_pkg::SACQ_NSRC-1:0][sacq_pkg::SACQ_DW-1:0] trig_src_i, // Trigger candidates
    input wire logic gate_pin_i, // Trigger gate pin, asynchronous
    output sacq_pkg::sacq_smp_s rec_o, // Samples to shot memory
    output sacq_pkg::sacq_strm_s strm_o, // Streaming samples to host path
    output logic trig_out_o // Scope-state trigger output pin
);
    import sacq_pkg::*;

    sacq_state_e state_q, state_d;
    logic [31:0] ctrl_q, strm_cfg_q;
    logic [15:0] pre_q, len_q, hold_q, level_q, cnt_q, hold_cnt_q, sdiv_q;
    logic [7:0] width_q, pulse_cnt_q;
    logic [2:0] gate_sync_q;
    logic gate_q, above_q, holding_q, force_q, start_q, trig_out_q, ack_q;
    logic [31:0] rdat_q;
    sacq_smp_s rec_q;
    sacq_strm_s strm_q;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_req & wb_we_i;
    wire [7:0] adr = wb_adr_i[7:0];

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : lane_merge

    wire [31:0] ctrl_w = lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
    wire [31:0] pre_w = lane_merge({16'h0000, pre_q}, wb_dat_i, wb_sel_i);
    wire [31:0] len_w = lane_merge({16'h0000, len_q}, wb_dat_i, wb_sel_i);
    wire [31:0] hold_w = lane_merge({16'h0000, hold_q}, wb_dat_i, wb_sel_i);
    wire [31:0] level_w = lane_merge({16'h0000, level_q}, wb_dat_i, wb_sel_i);
    wire [31:0] width_w = lane_merge({24'h000000, width_q}, wb_dat_i, wb_sel_i);
    wire [31:0] strm_w = lane_merge(strm_cfg_q, wb_dat_i, wb_sel_i);
    wire cmd_wr = bus_wr && adr == SACQ_A_CMD && wb_sel_i[0];
    wire cmd_start = cmd_wr & wb_dat_i[SACQ_K_START];
    wire cmd_stop = cmd_wr & wb_dat_i[SACQ_K_STOP];
    wire cmd_force = cmd_wr & wb_dat_i[SACQ_K_FORCE];

    wire [31:0] stat_w = {26'h0000000, holding_q, trig_out_q, 2'b00, state_q};
    wire [31:0] rd_w = (adr == SACQ_A_CTRL) ? ctrl_q :
                       (adr == SACQ_A_PRE) ? {16'h0000, pre_q} :
                       (adr == SACQ_A_LEN) ? {16'h0000, len_q} :
                       (adr == SACQ_A_HOLD) ? {16'h0000, hold_q} :
                       (adr == SACQ_A_LEVEL) ? {16'h0000, level_q} :
                       (adr == SACQ_A_WIDTH) ? {24'h000000, width_q} :
                       (adr == SACQ_A_STRM) ? strm_cfg_q :
                       (adr == SACQ_A_STAT) ? stat_w : SACQ_UNMAPPED;

    // Trigger selection and qualification
    wire [2:0] src_sel = ctrl_q[SACQ_C_SRC_HI:SACQ_C_SRC_LO];
    wire [SACQ_DW-1:0] trig_val = (src_sel < 3'(SACQ_NSRC)) ? trig_src_i[src_sel] : trig_src_i[0];
    wire above = $signed(trig_val) > $signed(level_q);
    wire rise = above & ~above_q;
    wire gate_ok = ~ctrl_q[SACQ_C_GATE_EN] | gate_q;
    wire trig_hit = (rise & gate_ok) | force_q;
    wire trig_en = ctrl_q[SACQ_C_TRIG_EN];
    wire smp_v = smp_i.valid;
    wire running = ctrl_q[SACQ_C_RUN];
    wire arm_go = state_q == SACQ_ARMED && (!trig_en || trig_hit) && !cmd_stop;
    wire sdiv_tick = sdiv_q == SACQ_ZERO;

    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            SACQ_IDLE: begin
                if (!holding_q && (start_q || running)) begin
                    state_d = SACQ_BUFFER;
                end
            end
            SACQ_BUFFER: begin
                if (cnt_q >= pre_q) begin
                    state_d = SACQ_ARMED;
                end
            end
            SACQ_ARMED: begin
                if (arm_go) begin
                    state_d = SACQ_ACTIVE;
                end
            end
            SACQ_ACTIVE: begin
                if (smp_v && cnt_q + SACQ_ONE >= len_q) begin
                    state_d = SACQ_IDLE;
                end
            end
            default: state_d = SACQ_IDLE;
        endcase
        if (cmd_stop) begin
            state_d = SACQ_IDLE;
        end
    end

    // Output selection
    wire pulse_on = arm_go || pulse_cnt_q != 8'h00;
    wire [2:0] osel = ctrl_q[SACQ_C_OSEL_HI:SACQ_C_OSEL_LO];
    wire st_armed = state_d == SACQ_ARMED;
    wire st_active = state_d == SACQ_ACTIVE;
    wire tout_d = (osel == SACQ_OUT_TRIG) ? pulse_on :
                  (osel == SACQ_OUT_TRIG_N) ? ~pulse_on :
                  (osel == SACQ_OUT_ARMED) ? st_armed :
                  (osel == SACQ_OUT_ARMED_N) ? ~st_armed :
                  (osel == SACQ_OUT_ACTIVE) ? st_active :
                  (osel == SACQ_OUT_ACTIVE_N) ? ~st_active : 1'b0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q <= SACQ_CTRL_RST;
            pre_q <= SACQ_PRE_RST;
            len_q <= SACQ_LEN_RST;
            hold_q <= SACQ_HOLD_RST;
            level_q <= SACQ_LEVEL_RST;
            width_q <= SACQ_WIDTH_RST;
            strm_cfg_q <= SACQ_STRM_RST;
            ack_q <= 1'b0;
            rdat_q <= SACQ_UNMAPPED;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                rdat_q <= rd_w;
            end
            if (bus_wr && adr == SACQ_A_CTRL) begin
                ctrl_q <= ctrl_w;
            end
            if (bus_wr && adr == SACQ_A_PRE) begin
                pre_q <= pre_w[15:0];
            end
            if (bus_wr && adr == SACQ_A_LEN) begin
                len_q <= len_w[15:0];
            end
            if (bus_wr && adr == SACQ_A_HOLD) begin
                hold_q <= hold_w[15:0];
            end
            if (bus_wr && adr == SACQ_A_LEVEL) begin
                level_q <= level_w[15:0];
            end
            if (bus_wr && adr == SACQ_A_WIDTH) begin
                width_q <= width_w[7:0];
            end
            if (bus_wr && adr == SACQ_A_STRM) begin
                strm_cfg_q <= strm_w;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= SACQ_IDLE;
            cnt_q <= SACQ_ZERO;
            hold_cnt_q <= SACQ_ZERO;
            holding_q <= 1'b0;
            start_q <= 1'b0;
            force_q <= 1'b0;
            above_q <= 1'b1;
            gate_sync_q <= 3'b000;
            gate_q <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_sync_q <= {gate_sync_q[1:0], gate_pin_i};
            if (gate_sync_q[2] == gate_sync_q[1]) begin
                gate_q <= gate_sync_q[2];
            end
            above_q <= above;
            start_q <= (start_q | cmd_start) & ~(state_d == SACQ_BUFFER) & ~cmd_stop;
            force_q <= (force_q | cmd_force) & ~arm_go & (state_q != SACQ_IDLE || cmd_force);
            if (state_d != state_q) begin
                cnt_q <= SACQ_ZERO;
            end else if (smp_v && state_q != SACQ_IDLE) begin
                cnt_q <= cnt_q + SACQ_ONE;
            end
            if (state_q == SACQ_ACTIVE && state_d == SACQ_IDLE) begin
                holding_q <= 1'b1;
                hold_cnt_q <= hold_q;
            end else if (holding_q) begin
                if (hold_cnt_q == SACQ_ZERO) begin
                    holding_q <= 1'b0;
                end else begin
                    hold_cnt_q <= hold_cnt_q - SACQ_ONE;
                end
            end
        end
    end

    // Trigger output
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pulse_cnt_q <= 8'h00;
            trig_out_q <= 1'b0;
        end else begin
            if (arm_go) begin
                pulse_cnt_q <= width_q;
            end else if (pulse_cnt_q != 8'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
            end
            trig_out_q <= tout_d;
        end
    end

    // Shot recording and streaming paths
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rec_q <= '0;
            strm_q <= '0;
            sdiv_q <= SACQ_ZERO;
        end else begin
            rec_q.valid <= smp_v && state_q != SACQ_IDLE;
            rec_q.data <= smp_i.data;
            if (smp_v) begin
                sdiv_q <= sdiv_tick ? strm_cfg_q[SACQ_S_DIV_HI:SACQ_S_DIV_LO] : sdiv_q - SACQ_ONE;
            end
            for (int c = 0; c < SACQ_NCH; c++) begin
                strm_q.valid[c] <= smp_v && sdiv_tick && strm_cfg_q[SACQ_S_EN0 + c];
                strm_q.data[c] <= (c == 0) ? smp_i.data : trig_val;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign rec_o = rec_q;
    assign strm_o = strm_q;
    assign trig_out_o = trig_out_q;

    armed_out_a: assert property (@(posedge clk_sys) disable iff (srst)
        osel == SACQ_OUT_ARMED |=> trig_out_q == (state_q == SACQ_ARMED))
        else $error("armed output does not follow armed state");
    armed_inv_a: assert property (@(posedge clk_sys) disable iff (srst)
        osel == SACQ_OUT_ARMED_N |=> trig_out_q == (state_q != SACQ_ARMED))
        else $error("inverted armed output wrong");
    active_out_a: assert property (@(posedge clk_sys) disable iff (srst)
        osel[2:1] == 2'b10 |=> trig_out_q == ((state_q == SACQ_ACTIVE) ^ $past(osel[0])))
        else $error("active output wrong");
    pulse_start_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ARMED && state_d == SACQ_ACTIVE && osel == SACQ_OUT_TRIG |=> trig_out_q)
        else $error("no pulse on trigger");
    pulse_inv_a: assert property (@(posedge clk_sys) disable iff (srst)
        arm_go && osel == SACQ_OUT_TRIG_N |=> !trig_out_q)
        else $error("inverted pulse not low");
    gate_block_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ARMED && trig_en && ctrl_q[SACQ_C_GATE_EN] && !gate_q && !force_q && !cmd_stop
        |=> state_q == SACQ_ARMED)
        else $error("trigger taken with gate closed");
    no_trig_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ARMED && !trig_en && !cmd_stop |=> state_q == SACQ_ACTIVE)
        else $error("armed not passed through");
    hold_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(state_q == SACQ_ACTIVE) && state_q == SACQ_IDLE |-> holding_q && state_d == SACQ_IDLE)
        else $error("restart without hold-off");
    start_buf_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_IDLE && !holding_q && start_q && !cmd_stop |=> state_q == SACQ_BUFFER)
        else $error("start did not enter buffer");

    // Sequencing, hold-off, pulse and streaming checks
    reset_idle_a: assert property (@(posedge clk_sys)
        srst |=> state_q == SACQ_IDLE && !trig_out_q && !ack_q && !rec_q.valid && strm_q.valid == 2'b00)
        else $error("reset did not reach idle");
    buf_done_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_BUFFER && cnt_q >= pre_q && !cmd_stop |=> state_q == SACQ_ARMED)
        else $error("buffer did not arm");
    buf_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_BUFFER && cnt_q < pre_q |=> state_q == SACQ_BUFFER || state_q == SACQ_IDLE)
        else $error("armed before pre-trigger filled");
    trig_now_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ARMED && trig_hit && !cmd_stop |=> state_q == SACQ_ACTIVE)
        else $error("trigger did not start shot");
    edge_only_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ARMED && trig_en && !rise && !force_q |=> state_q != SACQ_ACTIVE)
        else $error("shot started without rising crossing");
    shot_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ACTIVE && !smp_v && !cmd_stop |=> state_q == SACQ_ACTIVE)
        else $error("shot ended without sample");
    shot_done_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_ACTIVE && smp_v && cnt_q + SACQ_ONE >= len_q |=> state_q == SACQ_IDLE)
        else $error("shot ran past length");
    hold_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        holding_q |=> state_q == SACQ_IDLE)
        else $error("left idle during hold-off");
    hold_len_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(holding_q) |-> hold_cnt_q == $past(hold_q))
        else $error("hold-off count not loaded");
    restart_run_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_IDLE && !holding_q && running && !cmd_stop |=> state_q == SACQ_BUFFER)
        else $error("run mode did not restart");
    pulse_load_a: assert property (@(posedge clk_sys) disable iff (srst)
        arm_go |=> pulse_cnt_q == $past(width_q))
        else $error("pulse width not loaded");
    pulse_end_a: assert property (@(posedge clk_sys) disable iff (srst)
        osel == SACQ_OUT_TRIG && !arm_go && pulse_cnt_q == 8'h00 |=> !trig_out_q)
        else $error("pulse output stuck high");
    rec_armed_a: assert property (@(posedge clk_sys) disable iff (srst)
        smp_v && state_q == SACQ_ARMED |=> rec_q.valid)
        else $error("armed sample not recorded");
    rec_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        state_q == SACQ_IDLE |=> !rec_q.valid)
        else $error("sample recorded while idle");
    strm_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
        !strm_cfg_q[SACQ_S_EN1] |=> !strm_q.valid[1])
        else $error("disabled channel streamed");
    strm_pass_a: assert property (@(posedge clk_sys) disable iff (srst)
        smp_v && sdiv_tick && strm_cfg_q[SACQ_S_EN0]
        |=> strm_q.valid[0] && strm_q.data[0] == $past(smp_i.data))
        else $error("sample not streamed");
    strm_rate_a: assert property (@(posedge clk_sys) disable iff (srst)
        smp_v && !sdiv_tick |=> strm_q.valid == 2'b00)
        else $error("stream divider ignored");

endmodule : sacq_top

// *** testbench/sacq_far.sv ***
// Far-side model: shot memory tap, host stream sink and trigger output reader
`timescale 1ns/1ps
module sacq_far (
    input wire logic clk_sys, // System clock
    input wire sacq_pkg::sacq_smp_s rec_i, // Samples bound for shot memory
    input wire sacq_pkg::sacq_strm_s strm_i, // Streamed samples
    input wire logic trig_i, // Trigger output pin
    output int rec_cnt, // Shot samples seen
    output int s0_cnt, // Channel 0 stream samples
    output int s1_cnt, // Channel 1 stream samples
    output logic [15:0] s0_last, // Last channel 0 stream value
    output logic [15:0] s1_last, // Last channel 1 stream value
    output logic [15:0] rec_last, // Last shot memory value
    output int pw // Length of the last high pulse
);
    import sacq_pkg::*;
    int hi;
    initial begin
        rec_cnt = 0;
        s0_cnt = 0;
        s1_cnt = 0;
        s0_last = 16'h0;
        s1_last = 16'h0;
        rec_last = 16'h0;
        pw = 0;
        hi = 0;
    end
    always @(posedge clk_sys) begin
        if (rec_i.valid === 1'b1) begin
            rec_cnt <= rec_cnt + 1;
            rec_last <= rec_i.data;
        end
        if (strm_i.valid[0] === 1'b1) begin
            s0_cnt <= s0_cnt + 1;
            s0_last <= strm_i.data[0];
        end
        if (strm_i.valid[1] === 1'b1) begin
            s1_cnt <= s1_cnt + 1;
            s1_last <= strm_i.data[1];
        end
        hi <= (trig_i === 1'b1) ? hi + 1 : 0;
        // Width is latched when the pulse ends
        if (trig_i !== 1'b1 && hi != 0) begin
            pw <= hi;
        end
    end
endmodule : sacq_far

// *** testbench/tb_sacq_top.sv ***
// Self-checking testbench for the scope acquisition sequencer
`timescale 1ns/1ps
module tb_sacq_top;
    import sacq_pkg::*;
    logic clk_sys, srst, we, cyc, stb, gate, ack, trig;
    logic [31:0] adr, wdat, rdat, r;
    logic [3:0] sel;
    sacq_smp_s smp, rec;
    sacq_strm_s strm;
    logic [SACQ_NSRC-1:0][SACQ_DW-1:0] tsrc;
    logic [15:0] s0_last, s1_last, rec_last;
    int rec_cnt, s0_cnt, s1_cnt, pw, mismatches, checked, b0, b1;
    sacq_top i_dut (.clk_sys(clk_sys), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .smp_i(smp),
        .trig_src_i(tsrc), .gate_pin_i(gate), .rec_o(rec), .strm_o(strm), .trig_out_o(trig));
    sacq_far i_far (.clk_sys(clk_sys), .rec_i(rec), .strm_i(strm), .trig_i(trig), .rec_cnt(rec_cnt),
        .s0_cnt(s0_cnt), .s1_cnt(s1_cnt), .s0_last(s0_last), .s1_last(s1_last), .rec_last(rec_last), .pw(pw));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic conclude;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {24'h0, a};
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_sys);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic push(input int n, input logic [15:0] v);
        repeat (n) begin
            @(posedge clk_sys);
            smp <= '{valid: 1'b1, data: v};
            @(posedge clk_sys);
            smp.valid <= 1'b0;
        end
    endtask : push
    task automatic st(input logic [1:0] s, input logic t);
        wb(1'b0, SACQ_A_STAT, 32'h0);
        chk({30'h0, r[1:0]}, {30'h0, s});
        chk({31'h0, trig}, {31'h0, t});
    endtask : st
    function automatic logic [31:0] ctl(input logic te, ge, rn, input logic [2:0] src, osel);
        return {21'h0, osel, 1'b0, src, 1'b0, rn, ge, te};
    endfunction : ctl
    task automatic t_reset;
        chk({31'h0, trig}, 32'h0);
        st(2'b00, 1'b0);
        wb(1'b0, SACQ_A_CTRL, 32'h0);
        chk(r, SACQ_CTRL_RST);
        wb(1'b0, SACQ_A_PRE, 32'h0);
        chk(r, {16'h0, SACQ_PRE_RST});
        wb(1'b1, 8'h30, 32'hffff_ffff);
        wb(1'b0, 8'h30, 32'h0);
        chk(r, SACQ_UNMAPPED);
        $display("test reset done");
    endtask : t_reset
    task automatic t_osel;
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, SACQ_A_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h0, i[2:0]));
            repeat (2) @(posedge clk_sys);
            chk({31'h0, trig}, {31'h0, i[0]});
        end
        $display("test output select done");
    endtask : t_osel
    task automatic t_notrig;
        wb(1'b1, SACQ_A_HOLD, 32'h2);
        wb(1'b1, SACQ_A_PRE, 32'h2);
        wb(1'b1, SACQ_A_LEN, 32'h3);
        wb(1'b1, SACQ_A_CTRL, ctl(1'b0, 1'b0, 1'b0, 3'h0, SACQ_OUT_ACTIVE));
        b0 = rec_cnt;
        wb(1'b1, SACQ_A_CMD, 32'h1);
        st(2'b01, 1'b0);
        push(2, 16'h0011);
        repeat (2) @(posedge clk_sys);
        st(2'b11, 1'b1);
        push(3, 16'h0022);
        st(2'b00, 1'b0);
        chk(rec_cnt - b0, 32'h5);
        chk({16'h0, rec_last}, 32'h0022);
        $display("test free run done");
    endtask : t_notrig
    task automatic t_edge;
        tsrc[2] <= 16'h0032;
        wb(1'b1, SACQ_A_LEVEL, 32'h64);
        wb(1'b1, SACQ_A_CTRL, ctl(1'b1, 1'b1, 1'b0, 3'h2, SACQ_OUT_ARMED));
        wb(1'b1, SACQ_A_PRE, 32'h4);
        wb(1'b1, SACQ_A_CMD, 32'h1);
        push(4, 16'h0033);
        st(2'b10, 1'b1);
        b0 = rec_cnt;
        tsrc[2] <= 16'h00c8;
        push(1, 16'h0044);
        st(2'b10, 1'b1);
        tsrc[2] <= 16'h0032;
        gate <= 1'b1;
        push(4, 16'h0055);
        st(2'b10, 1'b1);
        chk(rec_cnt - b0, 32'h5);
        tsrc[2] <= 16'h00c8;
        push(1, 16'h0066);
        st(2'b11, 1'b0);
        push(3, 16'h0077);
        st(2'b00, 1'b0);
        $display("test edge trigger done");
    endtask : t_edge
    task automatic t_pulse;
        wb(1'b1, SACQ_A_WIDTH, 32'h3);
        wb(1'b1, SACQ_A_PRE, 32'h2);
        wb(1'b1, SACQ_A_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h1, SACQ_OUT_TRIG));
        wb(1'b1, SACQ_A_CMD, 32'h1);
        push(2, 16'h0088);
        st(2'b10, 1'b0);
        wb(1'b1, SACQ_A_CMD, 32'h4);
        repeat (8) @(posedge clk_sys);
        chk(pw, 32'h4);
        push(3, 16'h0099);
        st(2'b00, 1'b0);
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_hold;
        wb(1'b1, SACQ_A_HOLD, 32'ha);
        wb(1'b1, SACQ_A_PRE, 32'h1);
        wb(1'b1, SACQ_A_LEN, 32'h1);
        wb(1'b1, SACQ_A_CTRL, ctl(1'b0, 1'b0, 1'b1, 3'h0, SACQ_OUT_ARMED_N));
        push(3, 16'h00aa);
        wb(1'b0, SACQ_A_STAT, 32'h0);
        chk(r & 32'h23, 32'h20);
        repeat (14) @(posedge clk_sys);
        st(2'b01, 1'b1);
        wb(1'b1, SACQ_A_CTRL, ctl(1'b0, 1'b0, 1'b0, 3'h0, SACQ_OUT_ARMED_N));
        wb(1'b1, SACQ_A_CMD, 32'h2);
        st(2'b00, 1'b1);
        $display("test hold-off done");
    endtask : t_hold
    task automatic t_mid;
        wb(1'b1, SACQ_A_CTRL, ctl(1'b0, 1'b0, 1'b1, 3'h0, SACQ_OUT_ARMED_N));
        repeat (4) @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        chk({31'h0, trig}, 32'h0);
        st(2'b00, 1'b0);
        wb(1'b0, SACQ_A_CTRL, 32'h0);
        chk(r, SACQ_CTRL_RST);
        $display("test mid-run reset done");
    endtask : t_mid
    task automatic t_strm;
        b0 = s0_cnt;
        b1 = s1_cnt;
        wb(1'b1, SACQ_A_STRM, 32'h0000_0101);
        push(6, 16'h0abc);
        repeat (3) @(posedge clk_sys);
        chk(s0_cnt - b0, 32'h3);
        chk(s1_cnt - b1, 32'h0);
        chk({16'h0, s0_last}, 32'h0abc);
        b0 = s0_cnt;
        b1 = s1_cnt;
        tsrc[4] <= 16'h0777;
        wb(1'b1, SACQ_A_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h4, SACQ_OUT_TRIG));
        wb(1'b1, SACQ_A_STRM, 32'h3);
        push(4, 16'h0bcd);
        repeat (3) @(posedge clk_sys);
        chk(s0_cnt - b0, 32'h4);
        chk(s1_cnt - b1, 32'h4);
        chk({16'h0, s1_last}, 32'h0777);
        wb(1'b1, SACQ_A_STRM, 32'h0);
        $display("test streaming done");
    endtask : t_strm
    initial begin
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 32'h0;
        wdat = 32'h0;
        smp = '0;
        tsrc = '0;
        gate = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset;
        t_osel;
        t_notrig;
        t_edge;
        t_pulse;
        t_hold;
        t_mid;
        t_strm;
        conclude;
    end
    initial begin
        #100000;
        mismatches++;
        conclude;
    end
endmodule : tb_sacq_top
